// File: ssoc_cc_fsm.sv
// sink-role type-c state machine with debug accessory support
`default_nettype none
module ssoc_cc_fsm
  import ssoc_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // synchronised cc levels and bus sense
  input  wire logic [1:0] cc1_lvl,
  input  wire logic [1:0] cc2_lvl,
  input  wire logic       vbus_ok,
  // attach results
  output logic            src_att_ff,
  output logic            dbg_att_ff,
  output logic            flip_ff,
  output logic [1:0]      cur_ff
);
  localparam int CW = $clog2(DEB_CYC + 1);
  localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYC - 1);

  // refuse a debounce window the counter cannot time
  if (DEB_CYC < 2) begin : g_bad_deb
    $error("debounce count too small");
  end

  ssoc_cc_state_e state_ff;           // current state
  logic [CW-1:0]  cnt_ff;             // debounce counter
  logic [1:0]     snap1_ff, snap2_ff; // levels being debounced
  logic           rp1, rp2;           // source pull-up seen per pin

  assign rp1 = (cc1_lvl != CC_OPEN);
  assign rp2 = (cc2_lvl != CC_OPEN);

  // state transitions, debounced on stable cc levels
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff <= SSOC_UNATTACHED;
      cnt_ff   <= '0;
      snap1_ff <= CC_OPEN;
      snap2_ff <= CC_OPEN;
      flip_ff  <= 1'b0;
    end else begin
      case (state_ff)
        SSOC_UNATTACHED: begin
          cnt_ff   <= '0;
          snap1_ff <= cc1_lvl;
          snap2_ff <= cc2_lvl;
          if (rp1 || rp2) state_ff <= SSOC_ATTACH_WAIT;
        end
        SSOC_ATTACH_WAIT: begin
          if (!rp1 && !rp2) begin
            state_ff <= SSOC_UNATTACHED;
          end else if (cc1_lvl != snap1_ff || cc2_lvl != snap2_ff) begin
            // level moved: restart the debounce window
            snap1_ff <= cc1_lvl;
            snap2_ff <= cc2_lvl;
            cnt_ff   <= '0;
          end else if (cnt_ff != DEB_LAST) begin
            cnt_ff <= cnt_ff + 1'b1;
          end else if (rp1 && rp2) begin
            // pull-ups on both pins mean a debug accessory
            state_ff <= SSOC_ATTACHED_DBG;
          end else if (vbus_ok) begin
            state_ff <= SSOC_ATTACHED_SRC;
            flip_ff  <= rp2;
          end
        end
        SSOC_ATTACHED_SRC: begin
          // bus lost or active pin opened: detach
          if (!vbus_ok || (flip_ff ? !rp2 : !rp1)) state_ff <= SSOC_UNATTACHED;
        end
        SSOC_ATTACHED_DBG: begin
          if (!rp1 && !rp2) state_ff <= SSOC_UNATTACHED;
        end
        default: state_ff <= SSOC_UNATTACHED;
      endcase
    end
  end

  // registered attach flags and advertised current
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      src_att_ff <= 1'b0;
      dbg_att_ff <= 1'b0;
      cur_ff     <= CC_OPEN;
    end else begin
      src_att_ff <= (state_ff == SSOC_ATTACHED_SRC);
      dbg_att_ff <= (state_ff == SSOC_ATTACHED_DBG);
      cur_ff     <= (state_ff == SSOC_ATTACHED_SRC) ? (flip_ff ? cc2_lvl : cc1_lvl) : CC_OPEN;
    end
  end
endmodule
`default_nettype wire

// File: ssoc_drain_timer.sv
// bus drain timer: holds the drain active for the configured time
`default_nettype none
module ssoc_drain_timer
  import ssoc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC,
  parameter int unsigned UNIT_MS   = DRAIN_UNIT_MS
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // start pulse and duration in units
  input  wire logic       trigger,
  input  wire logic [3:0] dur,
  // drain active level
  output logic            active_ff
);
  localparam int DW = $clog2(MS_CYCLES + 1);
  localparam int RW = $clog2(15 * UNIT_MS + 1);

  // refuse a divider or unit the counters cannot serve
  if (MS_CYCLES < 2 || UNIT_MS < 1) begin : g_bad_drain
    $error("drain timer parameters out of range");
  end

  logic [DW-1:0] div_ff;   // millisecond divider
  logic [RW-1:0] left_ff;  // milliseconds remaining
  logic          ms_tick;  // one-cycle enable every millisecond

  assign ms_tick = (div_ff == DW'(MS_CYCLES - 1));

  // divider runs only while draining; a retrigger restarts the time
  always_ff @(posedge sys_clk) begin
    if (!resetn || trigger || !active_ff || ms_tick) div_ff <= '0;
    else div_ff <= div_ff + 1'b1;
  end

  // remaining time; zero duration means no drain at all
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      left_ff   <= '0;
      active_ff <= 1'b0;
    end else if (trigger) begin
      left_ff   <= RW'(dur * UNIT_MS);
      active_ff <= (dur != 4'h0);
    end else if (active_ff && ms_tick) begin
      left_ff <= left_ff - 1'b1;
      if (left_ff == RW'(1)) active_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: ssoc_host_model.sv
// host side of the pins: pull-ups on every open-drain output
`default_nettype none
module ssoc_host_model (
  // pull-low enables from the block
  input  wire logic [7:0] pull_low,
  // pin levels seen by switches and host
  output logic [7:0]      pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released pin floats up, never keeps its last level
  assign pin_lvl = ~pull_low;
endmodule
`default_nettype wire

// File: ssoc_pkg.sv
// constants and types shared by the sink status output control block
`default_nettype none
package ssoc_pkg;
  // clock rate of sys_clk
  localparam int unsigned CLK_MHZ = 100;
  // per-pin cc level encoding from the cc line comparators
  localparam logic [1:0] CC_OPEN = 2'h0;  // no source pull-up seen
  localparam logic [1:0] CC_DEF  = 2'h1;  // default usb current
  localparam logic [1:0] CC_1A5  = 2'h2;  // medium, 1.5 a
  localparam logic [1:0] CC_3A0  = 2'h3;  // high, 3.0 a
  // contract indicator configuration encodings
  localparam logic [1:0] IND_CFG_NONE    = 2'h0;
  localparam logic [1:0] IND_CFG_NA      = 2'h1;
  localparam logic [1:0] IND_CFG_PROFILE = 2'h2;
  localparam logic [1:0] IND_CFG_CURRENT = 2'h3;
  // multi-function pin configuration encodings
  localparam logic [1:0] MF_CFG_SOFTWARE = 2'h0;
  localparam logic [1:0] MF_CFG_FAULT    = 2'h1;
  localparam logic [1:0] MF_CFG_DEBUG    = 2'h2;
  localparam logic [1:0] MF_CFG_CURRENT  = 2'h3;
  // profile numbers as reported by the policy engine
  localparam logic [1:0] PROF_NONE = 2'h0;
  localparam logic [1:0] PROF_1    = 2'h1;
  localparam logic [1:0] PROF_2    = 2'h2;
  localparam logic [1:0] PROF_3    = 2'h3;
  // reset values latched for the configuration until the first load
  localparam logic [1:0] IND_CFG_RESET = IND_CFG_PROFILE;
  localparam logic [1:0] MF_CFG_RESET  = MF_CFG_FAULT;
  localparam logic       HV_ONLY_RESET = 1'b0;
  localparam logic [3:0] DRAIN_RESET   = 4'h0;
  // software pin control register
  localparam logic [7:0] SW_PIN_ADDR  = 8'h2d;
  localparam int unsigned SW_PIN_BIT  = 0;
  localparam logic       SW_PIN_RESET = 1'b0;
  // timing: cc debounce and drain time unit
  localparam int unsigned CC_DEBOUNCE_MS = 100;
  localparam int unsigned DEBOUNCE_CYC   = CC_DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int unsigned DRAIN_UNIT_MS  = 10;
  localparam int unsigned MS_CYC         = 1000 * CLK_MHZ;
  // type-c sink state machine states
  typedef enum logic [1:0] {
    SSOC_UNATTACHED,
    SSOC_ATTACH_WAIT,
    SSOC_ATTACHED_SRC,
    SSOC_ATTACHED_DBG
  } ssoc_cc_state_e;
endpackage
`default_nettype wire

// File: ssoc_top.sv
// sink status output control: open-drain status pins from attach and contract state
`default_nettype none
module ssoc_top
  import ssoc_pkg::*;
#(
  parameter int unsigned DEB_CYC   = DEBOUNCE_CYC,
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // cc comparator levels and bus sense, asynchronous
  input  wire logic [1:0] cc1_level,
  input  wire logic [1:0] cc2_level,
  input  wire logic       vbus_valid,
  // policy engine events, same clock
  input  wire logic       pe_ps_ready,
  input  wire logic [1:0] pe_contract_profile,
  input  wire logic       pe_request_sent,
  input  wire logic [1:0] pe_request_profile,
  input  wire logic       pe_lower_voltage,
  input  wire logic       pe_hard_reset,
  input  wire logic       error_recovery,
  input  wire logic       hw_fault,
  // non-volatile configuration fields
  input  wire logic [1:0] nvm_contract_ind_config,
  input  wire logic [1:0] nvm_gpio_config,
  input  wire logic       nvm_high_voltage_only_power,
  input  wire logic [3:0] nvm_drain_time,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // open-drain pull-low enables, high means pin driven low
  output logic            contract_ind_mid_oe,
  output logic            contract_ind_high_oe,
  output logic            software_driven_pin_oe,
  output logic            power_path_enable_n_oe,
  output logic            orientation_oe,
  output logic            attach_oe,
  output logic            external_drain_out_oe,
  output logic            bus_sense_and_drain_oe
);
  localparam int NSYNC = 5;

  // synchroniser stages for the pin inputs
  logic [NSYNC-1:0] meta_ff;        // first stage, read only by second
  logic [NSYNC-1:0] sync_ff;        // second stage, safe to use
  logic [NSYNC-1:0] pin_raw;        // raw pin bundle

  // latched configuration
  logic             cfg_loaded_ff;  // configuration taken
  logic [1:0]       ind_cfg_ff;     // contract indicator mode
  logic [1:0]       mf_cfg_ff;      // multi-function pin mode
  logic             hv_only_ff;     // power path only above 5 v
  logic [3:0]       drain_time_ff;  // drain duration in units

  // attach state from the cc state machine
  logic             src_att;        // source attached
  logic             dbg_att;        // debug accessory attached
  logic             flip;           // second cc pin active
  logic [1:0]       cur_lvl;        // advertised current
  logic             src_att_d_ff;   // previous source attach
  logic             new_attach;     // attach rising edge
  logic             detach;         // attach falling edge

  // contract tracking
  logic [1:0]       ind_prof_ff;    // profile shown on indicators
  logic [1:0]       contract_ff;    // explicit contract in force
  logic             sw_pin_ff;      // software pin register bit
  logic             drain_trig;     // drain start pulse
  logic             drain_active;   // drain timer running

  // registered pin enables
  logic             mid_ff, high_ff, mf_ff, path_ff, orient_ff, attach_ff, drain_ff;
  logic [7:0]       rdata_ff;
  logic             nxt_mid, nxt_high, nxt_mf, nxt_path;

  assign pin_raw = {vbus_valid, cc2_level, cc1_level};

  // two-flop synchronisers, one per pin bit
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= pin_raw[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  // configuration load once
  // taken on the first edge after reset release so straps never
  // reach a flop through the reset path; held until next reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfg_loaded_ff <= 1'b0;
      ind_cfg_ff    <= IND_CFG_RESET;
      mf_cfg_ff     <= MF_CFG_RESET;
      hv_only_ff    <= HV_ONLY_RESET;
      drain_time_ff <= DRAIN_RESET;
    end else if (!cfg_loaded_ff) begin
      cfg_loaded_ff <= 1'b1;
      ind_cfg_ff    <= nvm_contract_ind_config;
      mf_cfg_ff     <= nvm_gpio_config;
      hv_only_ff    <= nvm_high_voltage_only_power;
      drain_time_ff <= nvm_drain_time;
    end
  end

  ssoc_cc_fsm #(
    .DEB_CYC    (DEB_CYC)
  ) u_cc_fsm (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .cc1_lvl    (sync_ff[1:0]),
    .cc2_lvl    (sync_ff[3:2]),
    .vbus_ok    (sync_ff[4]),
    .src_att_ff (src_att),
    .dbg_att_ff (dbg_att),
    .flip_ff    (flip),
    .cur_ff     (cur_lvl)
  );

  // edge detect of the source attach flag
  always_ff @(posedge sys_clk) begin
    if (!resetn) src_att_d_ff <= 1'b0;
    else src_att_d_ff <= src_att;
  end

  assign new_attach = src_att && !src_att_d_ff;
  assign detach     = !src_att && src_att_d_ff;

  // indicator profile: what the contract pins report
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ind_prof_ff <= PROF_NONE;
    end else if (new_attach) begin
      ind_prof_ff <= PROF_NONE;
    end else if (pe_ps_ready) begin
      ind_prof_ff <= pe_contract_profile;
    end else if (pe_request_sent && pe_request_profile != ind_prof_ff) begin
      ind_prof_ff <= PROF_NONE;
    end
    // detach keeps indicators: no branch clears them here
  end

  // explicit contract in force, used by the power path
  // unlike the indicators this drops on detach, otherwise the path
  // could come back on a stale contract at the next attach
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      contract_ff <= PROF_NONE;
    end else if (!src_att || pe_hard_reset || error_recovery) begin
      contract_ff <= PROF_NONE;
    end else if (pe_ps_ready) begin
      contract_ff <= pe_contract_profile;
    end else if (pe_request_sent) begin
      // contract is in renegotiation until the next supply ready
      contract_ff <= PROF_NONE;
    end
  end

  // software pin register, reads back bit zero; upper bits read zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sw_pin_ff <= SW_PIN_RESET;
      rdata_ff  <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == SW_PIN_ADDR) sw_pin_ff <= reg_wdata[SW_PIN_BIT];
      // unmapped addresses read as zero
      if (reg_rd && reg_addr == SW_PIN_ADDR) rdata_ff <= {7'h00, sw_pin_ff};
      else if (reg_rd) rdata_ff <= 8'h00;
    end
  end

  // drain triggers
  // any of the four events restarts the drain timer
  assign drain_trig = detach || pe_lower_voltage || pe_hard_reset || error_recovery;

  ssoc_drain_timer #(
    .MS_CYCLES (MS_CYCLES),
    .UNIT_MS   (DRAIN_UNIT_MS)
  ) u_drain (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .trigger   (drain_trig),
    .dur       (drain_time_ff),
    .active_ff (drain_active)
  );

  // contract indicator selection
  always_comb begin
    nxt_mid  = 1'b0;
    nxt_high = 1'b0;
    case (ind_cfg_ff)
      IND_CFG_PROFILE: begin
        nxt_mid  = (ind_prof_ff == PROF_2);
        nxt_high = (ind_prof_ff == PROF_3);
      end
      IND_CFG_CURRENT: begin
        nxt_mid  = src_att && (cur_lvl == CC_3A0);
        nxt_high = src_att && (cur_lvl == CC_1A5);
      end
      default: begin
        nxt_mid  = 1'b0;
        nxt_high = 1'b0;
      end
    endcase
  end

  // power path selection
  always_comb begin
    if (hv_only_ff) begin
      nxt_path = src_att && (contract_ff == PROF_2 || contract_ff == PROF_3);
    end else begin
      // path follows attach, off at detach
      nxt_path = src_att;
    end
  end

  // multi-function pin selection
  always_comb begin
    case (mf_cfg_ff)
      MF_CFG_SOFTWARE: nxt_mf = sw_pin_ff;
      MF_CFG_FAULT:    nxt_mf = hw_fault;
      MF_CFG_DEBUG:    nxt_mf = dbg_att;
      // current mode: only 3.0 a pulls low
      MF_CFG_CURRENT:  nxt_mf = src_att && (cur_lvl == CC_3A0);
      default:         nxt_mf = 1'b0;
    endcase
  end

  // registered pin enables
  // every enable is released while reset is held, and the outputs
  // stay quiet until the configuration has been taken
  always_ff @(posedge sys_clk) begin
    if (!resetn || !cfg_loaded_ff) begin
      mid_ff    <= 1'b0;
      high_ff   <= 1'b0;
      mf_ff     <= 1'b0;
      path_ff   <= 1'b0;
      orient_ff <= 1'b0;
      attach_ff <= 1'b0;
      drain_ff  <= 1'b0;
    end else begin
      mid_ff    <= nxt_mid;
      high_ff   <= nxt_high;
      mf_ff     <= nxt_mf;
      path_ff   <= nxt_path;
      orient_ff <= src_att && flip;
      attach_ff <= src_att || dbg_att;
      drain_ff  <= drain_active;
    end
  end

  // outputs straight from the flops
  assign contract_ind_mid_oe    = mid_ff;
  assign contract_ind_high_oe   = high_ff;
  assign software_driven_pin_oe = mf_ff;
  assign power_path_enable_n_oe = path_ff;
  assign orientation_oe         = orient_ff;
  assign attach_oe              = attach_ff;
  // internal and external drain paths switch together
  assign external_drain_out_oe  = drain_ff;
  assign bus_sense_and_drain_oe = drain_ff;
  assign reg_rdata              = rdata_ff;
endmodule
`default_nettype wire

// File: ssoc_top_asserts.sv
// checker for the sink status output control pins
`default_nettype none
module ssoc_top_asserts
  import ssoc_pkg::*;
#(
  parameter int unsigned DEB_CYC   = 8,
  parameter int unsigned MS_CYCLES = 4
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       resetn,
  // events and configuration
  input wire logic       pe_ps_ready,
  input wire logic [1:0] pe_contract_profile,
  input wire logic       pe_request_sent,
  input wire logic [1:0] pe_request_profile,
  input wire logic       hw_fault,
  input wire logic [1:0] nvm_contract_ind_config,
  input wire logic [1:0] nvm_gpio_config,
  input wire logic       nvm_high_voltage_only_power,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pull-low enables
  input wire logic       contract_ind_mid_oe,
  input wire logic       contract_ind_high_oe,
  input wire logic       software_driven_pin_oe,
  input wire logic       power_path_enable_n_oe,
  input wire logic       orientation_oe,
  input wire logic       attach_oe,
  input wire logic       external_drain_out_oe,
  input wire logic       bus_sense_and_drain_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain, so defaults are set once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_release_idle: assert property (
    $rose(resetn) |-> !(contract_ind_mid_oe || contract_ind_high_oe || software_driven_pin_oe
    || power_path_enable_n_oe || attach_oe || bus_sense_and_drain_oe)) else $error("pin driven at reset exit");
  // supply ready sets indicator; three cycles covers either latency reading
  a_ready_sets: assert property (
    pe_ps_ready && pe_contract_profile == PROF_2 && nvm_contract_ind_config == IND_CFG_PROFILE
    |-> ##3 contract_ind_mid_oe && !contract_ind_high_oe) else $error("mid indicator not set");
  a_request_drops: assert property (
    pe_request_sent && pe_request_profile == PROF_3 && contract_ind_mid_oe
    && nvm_contract_ind_config == IND_CFG_PROFILE |-> ##3 !contract_ind_mid_oe) else $error("mid kept");
  a_detach_path: assert property (
    $fell(attach_oe) && nvm_contract_ind_config == IND_CFG_PROFILE |-> !power_path_enable_n_oe
    && !orientation_oe && $stable(contract_ind_high_oe)) else $error("detach outputs wrong");
  a_soft_pin: assert property (
    nvm_gpio_config == MF_CFG_SOFTWARE && reg_wr && reg_addr == SW_PIN_ADDR
    |-> ##3 software_driven_pin_oe == $past(reg_wdata[0], 3)) else $error("software pin wrong");
  // fault pin follows a steady fault
  a_fault_pin: assert property (
    nvm_gpio_config == MF_CFG_FAULT && $stable(hw_fault) [*5] |-> software_driven_pin_oe == hw_fault)
    else $error("fault pin wrong");
  a_hv_path: assert property (
    nvm_high_voltage_only_power && power_path_enable_n_oe |-> attach_oe) else $error("path without attach");
  a_orient_src: assert property (orientation_oe |-> attach_oe)
    else $error("orientation without attach");
  a_drain_pair: assert property (external_drain_out_oe == bus_sense_and_drain_oe)
    else $error("drain outputs differ");
  a_drain_hold: assert property (
    $rose(bus_sense_and_drain_oe) |-> bus_sense_and_drain_oe [*8]) else $error("drain too short");
  a_rdata_upper: assert property (reg_rdata[7:1] == 7'h00)
    else $error("upper read bits set");
  a_unmapped_rd: assert property (
    reg_rd && reg_addr != SW_PIN_ADDR |-> ##2 reg_rdata == 8'h00) else $error("unmapped read nonzero");
  // a read right after a write returns the written bit
  a_soft_readback: assert property (
    reg_wr && reg_addr == SW_PIN_ADDR ##1 reg_rd && reg_addr == SW_PIN_ADDR
    |=> reg_rdata == {7'h00, $past(reg_wdata[0], 2)}) else $error("software bit read back wrong");
endmodule
bind ssoc_top ssoc_top_asserts #(.DEB_CYC(DEB_CYC), .MS_CYCLES(MS_CYCLES)) i_ssoc_top_asserts (
  .sys_clk, .resetn, .pe_ps_ready, .pe_contract_profile, .pe_request_sent, .pe_request_profile,
  .hw_fault, .nvm_contract_ind_config, .nvm_gpio_config, .nvm_high_voltage_only_power, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .contract_ind_mid_oe, .contract_ind_high_oe,
  .software_driven_pin_oe, .power_path_enable_n_oe, .orientation_oe, .attach_oe,
  .external_drain_out_oe, .bus_sense_and_drain_oe);
`default_nettype wire

// File: ssoc_top_tb.sv
// self-checking bench for the sink status output control block
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module ssoc_top_tb
  import ssoc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // design inputs
  logic       sys_clk = 1'b0, resetn = 1'b0, vbus_valid = 1'b0, hw_fault = 1'b0;
  logic [1:0] cc1_level = CC_OPEN, cc2_level = CC_OPEN;
  logic       pe_ps_ready = 1'b0, pe_request_sent = 1'b0, pe_lower_voltage = 1'b0;
  logic       pe_hard_reset = 1'b0, error_recovery = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] pe_contract_profile = 2'h0, pe_request_profile = 2'h0;
  logic [1:0] gcfg = 2'h0, icfg = 2'h0, lvl = 2'h0;
  logic       hv = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  // design outputs and pin levels
  logic [7:0] reg_rdata;
  wire  [7:0] pull_low;
  wire  [7:0] pin_lvl;
  // reference model state
  int         seed = 32'h3ce6, miscompares = 0, check_count = 0, r, w;
  int         src, dbg, side, shown, con, sw, fault;
  logic       wq[$];
  // clock of 10 ns
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  ssoc_top #(.DEB_CYC(8), .MS_CYCLES(4)) i_ssoc_top (
    .sys_clk(sys_clk), .resetn(resetn), .cc1_level(cc1_level), .cc2_level(cc2_level),
    .vbus_valid(vbus_valid), .pe_ps_ready(pe_ps_ready), .pe_contract_profile(pe_contract_profile),
    .pe_request_sent(pe_request_sent), .pe_request_profile(pe_request_profile),
    .pe_lower_voltage(pe_lower_voltage), .pe_hard_reset(pe_hard_reset), .error_recovery(error_recovery),
    .hw_fault(hw_fault), .nvm_contract_ind_config(icfg), .nvm_gpio_config(gcfg),
    .nvm_high_voltage_only_power(hv), .nvm_drain_time(4'h1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .contract_ind_mid_oe(pull_low[7]),
    .contract_ind_high_oe(pull_low[6]), .software_driven_pin_oe(pull_low[5]),
    .power_path_enable_n_oe(pull_low[4]), .orientation_oe(pull_low[3]), .attach_oe(pull_low[2]),
    .external_drain_out_oe(pull_low[1]), .bus_sense_and_drain_oe(pull_low[0]));
  ssoc_host_model i_ssoc_host_model (.pull_low(pull_low), .pin_lvl(pin_lvl));
  // verdict and end of run
  task automatic stop_test();
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // inputs move only at falling edges
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // register write and read
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    `CHK("rdata", e, reg_rdata)
  endtask
  // bounded wait on the attach pin; a hang ends the run
  task automatic wait_att(logic v);
    int k;
    for (k = 0; k < 60 && pin_lvl[2] !== !v; k++) tick(1);
    if (k == 60) begin
      miscompares++;
      stop_test();
    end
  endtask
  // one event pulse, model updated alongside
  task automatic ev(int kind, logic [1:0] p);
    pe_contract_profile = p;
    pe_request_profile = p;
    case (kind)
      0: pe_ps_ready = 1'b1;
      1: pe_request_sent = 1'b1;
      2: pe_lower_voltage = 1'b1;
      3: pe_hard_reset = 1'b1;
      default: error_recovery = 1'b1;
    endcase
    if (kind == 0) begin
      shown = p;
      con = p;
    end
    if (kind == 1) begin
      con = 0;
      if (p != shown) shown = 0;
    end
    tick(1);
    {pe_ps_ready, pe_request_sent, pe_lower_voltage, pe_hard_reset, error_recovery} = 5'h00;
    tick(2);
  endtask
  // compare pins 7..2 with the model
  task automatic cmp_all();
    logic [7:2] e;
    e[7] = (icfg == IND_CFG_CURRENT) ? (src && lvl == CC_3A0) : (icfg == IND_CFG_PROFILE && shown == 2);
    e[6] = (icfg == IND_CFG_CURRENT) ? (src && lvl == CC_1A5) : (icfg == IND_CFG_PROFILE && shown == 3);
    case (gcfg)
      MF_CFG_SOFTWARE: e[5] = sw;
      MF_CFG_FAULT: e[5] = fault;
      MF_CFG_DEBUG: e[5] = dbg;
      default: e[5] = src && lvl == CC_3A0;
    endcase
    e[4] = src && (!hv || con >= 2);
    e[3] = src && side;
    e[2] = src || dbg;
    for (int i = 2; i < 8; i++) `CHK($sformatf("pin%0d", i), !e[i], pin_lvl[i])
  endtask
  // source pull-up on the pin chosen by side
  task automatic att_src();
    if (side) cc2_level = lvl;
    else cc1_level = lvl;
    vbus_valid = 1'b1;
    src = 1;
    shown = 0;
    wait_att(1);
    tick(2);
  endtask
  // main sequence: one pass per multi-function mode
  initial begin
    for (r = 0; r < 4; r++) begin
      gcfg = r[1:0];
      icfg = (r == 3) ? IND_CFG_CURRENT : (r == 2) ? IND_CFG_NONE : IND_CFG_PROFILE;
      hv = r[0];
      lvl = r[1] ? CC_3A0 : CC_1A5;
      side = r[0];
      fault = $random(seed) & 1;
      hw_fault = fault[0];
      {src, dbg, shown, con, sw} = '0;
      resetn = 1'b0;
      tick(6);
      resetn = 1'b1;
      tick(3);
      cmp_all();
      w = $random(seed);
      wq.push_back(w[0]);
      wr(SW_PIN_ADDR, w[7:0]);
      sw = w[0];
      rd(SW_PIN_ADDR, {7'h00, wq.pop_front()});
      rd(8'h2e, 8'h00);
      cmp_all();
      // debug accessory on both pins
      cc1_level = CC_DEF;
      cc2_level = CC_DEF;
      dbg = 1;
      wait_att(1);
      cmp_all();
      cc1_level = CC_OPEN;
      cc2_level = CC_OPEN;
      dbg = 0;
      wait_att(0);
      tick(50);
      att_src();
      cmp_all();
      ev(0, PROF_2);
      cmp_all();
      ev(1, PROF_3);
      cmp_all();
      ev(0, PROF_3);
      cmp_all();
      // detach: path off, indicators kept, drain runs
      cc1_level = CC_OPEN;
      cc2_level = CC_OPEN;
      vbus_valid = 1'b0;
      src = 0;
      con = 0;
      wait_att(0);
      tick(2);
      cmp_all();
      `CHK("drain", 2'b00, pin_lvl[1:0])
      tick(50);
      `CHK("drain", 2'b11, pin_lvl[1:0])
      ev(2 + (r % 3), PROF_NONE);
      `CHK("drain", 2'b00, pin_lvl[1:0])
      tick(50);
      // second attach uses the other advertised current and fault level
      lvl = (lvl == CC_3A0) ? CC_1A5 : CC_3A0;
      fault = !fault;
      hw_fault = fault[0];
      att_src();
      cmp_all();
    end
    stop_test();
  end
endmodule
`default_nettype wire
